// file: logic/event_unit_store.sv
// Small memory: per-unit event configuration words, registered read data.
// Assumes one write or read address per cycle from the register bank.
`timescale 1ns/1ps
`default_nettype none
module event_unit_store
  import ptp_config_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Write port
  input wire logic write_enable,
  input wire logic [2:0] write_addr,
  input wire logic [11:0] write_data,
  // Per-unit clear of edge enables
  input wire logic [event_units-1:0] clear_edges,
  // Read port
  input wire logic [2:0] read_addr,
  output logic [11:0] read_data,
  // Whole contents for the capture logic
  output logic [event_units*12-1:0] all_words
);
  logic [11:0] word_reg [event_units];
  genvar g;
  generate
    for (g = 0; g < event_units; g++) begin : g_word
      always_ff @(posedge clock) begin
        if (reset) begin
          word_reg[g] <= 12'h000;
        end else if (write_enable && write_addr == 3'(g)) begin
          word_reg[g] <= write_data;
        end else if (clear_edges[g]) begin
          word_reg[g] <= {2'b00, word_reg[g][9:0]};
        end
      end
      assign all_words[g*12 +: 12] = word_reg[g];
    end
  endgenerate
  always_ff @(posedge clock) begin
    if (reset) begin
      read_data <= 12'h000;
    end else begin
      read_data <= word_reg[read_addr];
    end
  end
endmodule
`default_nettype wire

// file: logic/ptp_config_pkg.sv
// Package: register map, field positions and constants of the timestamp configuration bank.
// Assumes registers are reached over the paged management port, page five selected.
package ptp_config_pkg;
  localparam logic [4:0] event_unit_config_addr = 5'h15;
  localparam logic [4:0] transmit_timestamp_config_addr = 5'h16;
  localparam logic [2:0] config_page = 3'h5;
  localparam logic [15:0] event_config_reset = 16'h0000;
  localparam logic [15:0] tx_config_reset = 16'h0000;
  // Event register fields
  localparam int ev_rise_bit = 14;
  localparam int ev_fall_bit = 13;
  localparam int ev_single_bit = 12;
  localparam int ev_pin_lsb = 8;
  localparam int ev_sel_lsb = 1;
  localparam int ev_wr_bit = 0;
  localparam logic [15:0] ev_writable_mask = 16'h7F0E;
  localparam int event_units = 8;
  localparam int event_pins = 12;
  localparam logic [3:0] max_pin = 4'hC;
  // Transmit register fields
  localparam int tx_sync1_bit = 15;
  localparam int tx_dr_bit = 13;
  localparam int tx_ntp_bit = 12;
  localparam int tx_ign2_bit = 11;
  localparam int tx_crc_bit = 10;
  localparam int tx_chk_bit = 9;
  localparam int tx_ipf_bit = 8;
  localparam int tx_l2_bit = 7;
  localparam int tx_v6_bit = 6;
  localparam int tx_v4_bit = 5;
  localparam int tx_ver_lsb = 1;
  localparam int tx_en_bit = 0;
  localparam logic [15:0] tx_writable_mask = 16'hBFFF;
  localparam logic [15:0] udp_port_event = 16'h013F;
  localparam logic [15:0] udp_port_ntp = 16'h007B;
  localparam int sync_depth = 3;
endpackage

// file: logic/ptp_event_tx_timestamp_config.sv
// Configuration bank for event timestamp units and transmit timestamping.
// Assumes a management block delivering decoded register strobes on page five.
`timescale 1ns/1ps
`default_nettype none
module ptp_event_tx_timestamp_config
  import ptp_config_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Management register port
  input wire logic [2:0] register_page_select,
  input wire logic [4:0] reg_addr,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  // General-purpose pins
  input wire logic [event_pins-1:0] gpio_in,
  // Event capture outputs
  output logic [event_units-1:0] event_capture,
  output logic [event_units-1:0] event_rise_dir,
  // Transmit frame information
  input wire logic frame_done,
  input wire logic [15:0] frame_udp_port,
  input wire logic frame_is_l2,
  input wire logic frame_is_v6,
  input wire logic frame_is_v4,
  input wire logic frame_is_sync,
  input wire logic frame_is_delay_req,
  input wire logic frame_two_step,
  input wire logic frame_crc_bad,
  input wire logic frame_ip_assigned,
  input wire logic [3:0] frame_version,
  input wire logic rx_insert_enable,
  // Transmit decisions
  output logic tx_capture,
  output logic one_step_insert,
  output logic checksum_fix,
  output logic force_crc_error,
  output logic delay_response_insert,
  output logic [15:0] parser_udp_port,
  // Configuration fields
  output logic [15:0] transmit_timestamp_config
);
  logic [2:0] event_unit_select_reg;
  logic [15:0] tx_cfg_reg;
  logic [15:0] tx_cfg_next;
  logic [11:0] store_rdata;
  logic [event_units*12-1:0] all_words;
  logic [event_units-1:0] clear_edges;
  logic [event_units-1:0] capture_reg;
  logic [event_units-1:0] rise_reg;
  logic [event_pins-1:0] pin_s1_reg;
  logic [event_pins-1:0] pin_s2_reg;
  logic [event_pins-1:0] pin_s3_reg;
  logic [event_pins-1:0] pin_level_reg;
  logic [event_pins-1:0] pin_prev_reg;
  logic [15:0] rdata_reg;
  logic read_pending_reg;
  logic tx_capture_reg;
  logic one_step_reg;
  logic force_crc_reg;

  // Register decode
  wire page_ok = register_page_select == config_page;
  wire ev_hit = page_ok && reg_addr == event_unit_config_addr;
  wire tx_hit = page_ok && reg_addr == transmit_timestamp_config_addr;
  wire ev_wr = ev_hit && reg_write;
  wire tx_wr = tx_hit && reg_write;
  wire ev_strobe = ev_wr && reg_wdata[ev_wr_bit];
  wire [2:0] sel_in = reg_wdata[ev_sel_lsb +: 3];
  wire [15:0] ev_masked = reg_wdata & ev_writable_mask;
  wire [11:0] store_wdata = {ev_masked[14:8], 1'b0, ev_masked[3:0]};
  wire [2:0] store_raddr = ev_wr ? sel_in : event_unit_select_reg;

  assign tx_cfg_next = tx_wr ? (reg_wdata & tx_writable_mask) : tx_cfg_reg;

  always_ff @(posedge clock) begin
    if (reset) begin
      event_unit_select_reg <= 3'h0;
      tx_cfg_reg <= tx_config_reset;
    end else begin
      if (ev_wr) begin
        event_unit_select_reg <= sel_in;
      end
      tx_cfg_reg <= tx_cfg_next;
    end
  end

  a_tx_reserved: assert property (@(posedge clock) disable iff (reset)
    tx_cfg_reg[14] == 1'b0)
    else $error("transmit reserved bit set");
  a_tx_write_lands: assert property (@(posedge clock) disable iff (reset)
    tx_wr
    |=> tx_cfg_reg == $past(reg_wdata & tx_writable_mask))
    else $error("transmit write did not land");
  a_off_page_hold: assert property (@(posedge clock) disable iff (reset)
    (reg_write && !page_ok)
    |=> $stable(tx_cfg_reg) && $stable(event_unit_select_reg))
    else $error("write off page changed a register");
  a_select_track: assert property (@(posedge clock) disable iff (reset)
    read_pending_reg
    |-> event_unit_select_reg == $past(sel_in))
    else $error("unit select not taken from write");

  event_unit_store u_store (
    .clock(clock),
    .reset(reset),
    .write_enable(ev_strobe),
    .write_addr(sel_in),
    .write_data(store_wdata),
    .clear_edges(clear_edges),
    .read_addr(store_raddr),
    .read_data(store_rdata),
    .all_words(all_words)
  );

  a_store_write: assert property (@(posedge clock) disable iff (reset)
    (ev_strobe && sel_in == 3'h0)
    |=> all_words[11:5] == $past(reg_wdata[14:8]))
    else $error("strobed write missed unit zero");
  a_keep_unstrobed: assert property (@(posedge clock) disable iff (reset)
    (ev_wr && !reg_wdata[ev_wr_bit] && !clear_edges[0])
    |=> $stable(all_words[11:0]))
    else $error("readback select altered unit zero");

  // Pin synchronisers, change accepted when stages two and three agree
  always_ff @(posedge clock) begin
    if (reset) begin
      pin_s1_reg <= '0;
      pin_s2_reg <= '0;
      pin_s3_reg <= '0;
      pin_level_reg <= '0;
      pin_prev_reg <= '0;
    end else begin
      pin_s1_reg <= gpio_in;
      pin_s2_reg <= pin_s1_reg;
      pin_s3_reg <= pin_s2_reg;
      pin_level_reg <= (pin_s2_reg & pin_s3_reg) | (pin_level_reg & (pin_s2_reg | pin_s3_reg));
      pin_prev_reg <= pin_level_reg;
    end
  end

  a_pin_agree: assert property (@(posedge clock) disable iff (reset)
    ((pin_level_reg ^ $past(pin_level_reg)) & ($past(pin_s2_reg) ^ $past(pin_s3_reg))) == '0)
    else $error("pin level moved before stages agreed");

  // Per-unit edge detection
  genvar u;
  generate
    for (u = 0; u < event_units; u++) begin : g_unit
      wire [11:0] word = all_words[u*12 +: 12];
      wire [3:0] pin_sel = word[8:5];
      wire pin_valid = pin_sel != 4'h0 && pin_sel <= max_pin;
      wire [3:0] pin_idx = pin_sel - 4'h1;
      wire cur = pin_valid ? pin_level_reg[pin_idx] : 1'b0;
      wire prv = pin_valid ? pin_prev_reg[pin_idx] : 1'b0;
      wire rise_hit = word[11] && cur && !prv;
      wire fall_hit = word[10] && !cur && prv;
      wire hit = rise_hit || fall_hit;
      assign clear_edges[u] = hit && word[9];
      always_ff @(posedge clock) begin
        if (reset) begin
          capture_reg[u] <= 1'b0;
          rise_reg[u] <= 1'b0;
        end else begin
          capture_reg[u] <= hit;
          if (hit) begin
            rise_reg[u] <= rise_hit;
          end
        end
      end
    end
  endgenerate

  assign event_capture = capture_reg;
  assign event_rise_dir = rise_reg;

  a_capture_enabled: assert property (@(posedge clock) disable iff (reset)
    event_capture[0]
    |-> $past(all_words[11] || all_words[10]))
    else $error("capture with both edges disabled");
  a_rise_dir: assert property (@(posedge clock) disable iff (reset)
    (event_capture[0] && event_rise_dir[0])
    |-> $past(all_words[11]))
    else $error("rising capture without rise enable");
  a_fall_dir: assert property (@(posedge clock) disable iff (reset)
    (event_capture[0] && !event_rise_dir[0])
    |-> $past(all_words[10]))
    else $error("falling capture without fall enable");
  a_no_pin_idle: assert property (@(posedge clock) disable iff (reset)
    (all_words[8:5] == 4'h0)
    |=> !event_capture[0])
    else $error("unrouted unit captured");
  a_bad_pin_idle: assert property (@(posedge clock) disable iff (reset)
    (all_words[8:5] > max_pin)
    |=> !event_capture[0])
    else $error("unit on invalid pin captured");
  a_single_clear: assert property (@(posedge clock) disable iff (reset)
    (clear_edges[0] && !(ev_strobe && sel_in == 3'h0))
    |=> all_words[11:10] == 2'b00)
    else $error("single capture left edges enabled");

  // Readback, event word assembled from selected unit
  wire [15:0] ev_read = {1'b0, store_rdata[11:5], 4'h0, store_rdata[3:1], 1'b0};
  wire [15:0] ev_view = {ev_read[15:4], event_unit_select_reg, 1'b0};

  always_ff @(posedge clock) begin
    if (reset) begin
      read_pending_reg <= 1'b0;
      rdata_reg <= 16'h0000;
    end else begin
      read_pending_reg <= ev_wr;
      if (tx_hit && reg_read) begin
        rdata_reg <= tx_cfg_reg;
      end else if (ev_hit && reg_read) begin
        rdata_reg <= ev_view;
      end else if (reg_read) begin
        rdata_reg <= 16'h0000;
      end
    end
  end
  assign reg_rdata = rdata_reg;

  a_reserved_zero: assert property (@(posedge clock) disable iff (reset)
    $past(ev_hit && reg_read)
    |-> reg_rdata[15] == 1'b0 && reg_rdata[7:4] == 4'h0)
    else $error("reserved event bits read nonzero");
  a_off_page_read: assert property (@(posedge clock) disable iff (reset)
    $past(reg_read && !page_ok)
    |-> reg_rdata == 16'h0000)
    else $error("read off page returned data");
  a_select_readback: assert property (@(posedge clock) disable iff (reset)
    $past(ev_hit && reg_read)
    |-> reg_rdata[3:1] == $past(event_unit_select_reg))
    else $error("readback shows wrong unit select");
  a_tx_readback: assert property (@(posedge clock) disable iff (reset)
    $past(tx_hit && reg_read)
    |-> reg_rdata == $past(tx_cfg_reg))
    else $error("transmit register read back wrong");

  // Transmit decisions
  wire cfg_sync1 = tx_cfg_reg[tx_sync1_bit];
  wire cfg_ver_ok = tx_cfg_reg[tx_ver_lsb +: 4] == 4'h0
    || tx_cfg_reg[tx_ver_lsb +: 4] == frame_version;
  wire [15:0] port_sel = tx_cfg_reg[tx_ntp_bit] ? udp_port_ntp : udp_port_event;
  wire is_udp = frame_is_v6 || frame_is_v4;
  wire encap_ok = (frame_is_l2 && tx_cfg_reg[tx_l2_bit])
    || (frame_is_v6 && tx_cfg_reg[tx_v6_bit])
    || (frame_is_v4 && tx_cfg_reg[tx_v4_bit]);
  wire port_ok = !is_udp || frame_udp_port == port_sel;
  wire ip_ok = !is_udp || !tx_cfg_reg[tx_ipf_bit] || frame_ip_assigned;
  wire frame_ok = encap_ok && port_ok && ip_ok && cfg_ver_ok;
  wire cap_now = frame_done && frame_ok && tx_cfg_reg[tx_en_bit];
  wire step_ok = !frame_two_step || tx_cfg_reg[tx_ign2_bit];
  // A one-step insert is a transmit capture as well
  wire insert_now = cap_now && frame_is_sync && cfg_sync1 && step_ok;

  always_ff @(posedge clock) begin
    if (reset) begin
      tx_capture_reg <= 1'b0;
      one_step_reg <= 1'b0;
      force_crc_reg <= 1'b0;
    end else begin
      tx_capture_reg <= cap_now;
      one_step_reg <= insert_now;
      force_crc_reg <= insert_now && frame_crc_bad && !tx_cfg_reg[tx_crc_bit];
    end
  end

  assign tx_capture = tx_capture_reg;
  assign one_step_insert = one_step_reg;
  assign force_crc_error = force_crc_reg;
  assign checksum_fix = tx_cfg_reg[tx_chk_bit] && !frame_is_l2;
  assign delay_response_insert = tx_cfg_reg[tx_dr_bit] && rx_insert_enable;
  assign parser_udp_port = port_sel;
  assign transmit_timestamp_config = tx_cfg_reg;

  // Transmit decision checks
  a_capture_gate: assert property (@(posedge clock) disable iff (reset)
    tx_capture
    |-> $past(tx_cfg_reg[tx_en_bit] && frame_done))
    else $error("transmit capture while disabled");
  a_tx_capture_ver: assert property (@(posedge clock) disable iff (reset)
    tx_capture
    |-> ($past(tx_cfg_reg[4:1]) == 4'h0 || $past(tx_cfg_reg[4:1]) == $past(frame_version)))
    else $error("capture with version mismatch");
  a_port_select: assert property (@(posedge clock) disable iff (reset)
    parser_udp_port == (tx_cfg_reg[tx_ntp_bit] ? 16'h007B : 16'h013F))
    else $error("wrong parser port");
  a_encap_gate: assert property (@(posedge clock) disable iff (reset)
    tx_capture
    |-> $past((frame_is_l2 && tx_cfg_reg[tx_l2_bit]) || (frame_is_v6 && tx_cfg_reg[tx_v6_bit])
      || (frame_is_v4 && tx_cfg_reg[tx_v4_bit])))
    else $error("capture on disabled encapsulation");
  a_ip_filter: assert property (@(posedge clock) disable iff (reset)
    (frame_done && (frame_is_v4 || frame_is_v6) && tx_cfg_reg[tx_ipf_bit] && !frame_ip_assigned)
    |=> !tx_capture)
    else $error("capture despite address filter");
  a_port_filter: assert property (@(posedge clock) disable iff (reset)
    (frame_done && (frame_is_v4 || frame_is_v6) && frame_udp_port != parser_udp_port)
    |=> !tx_capture)
    else $error("capture on wrong udp port");
  a_sync_only: assert property (@(posedge clock) disable iff (reset)
    one_step_insert
    |-> $past(frame_is_sync && tx_cfg_reg[tx_sync1_bit]))
    else $error("insert without one-step sync");
  a_insert_capture: assert property (@(posedge clock) disable iff (reset)
    one_step_insert
    |-> tx_capture)
    else $error("insert without timestamp capture");
  a_two_step_skip: assert property (@(posedge clock) disable iff (reset)
    (frame_done && frame_two_step && !tx_cfg_reg[tx_ign2_bit])
    |=> !one_step_insert)
    else $error("insertion despite two-step flag");
  a_crc_force: assert property (@(posedge clock) disable iff (reset)
    force_crc_error
    |-> one_step_insert && $past(frame_crc_bad) && !$past(tx_cfg_reg[tx_crc_bit]))
    else $error("crc error forced wrongly");
  a_crc_bad_forced: assert property (@(posedge clock) disable iff (reset)
    (one_step_insert && $past(frame_crc_bad) && !$past(tx_cfg_reg[tx_crc_bit]))
    |-> force_crc_error)
    else $error("bad crc frame sent without forced error");
  a_checksum_l2: assert property (@(posedge clock) disable iff (reset)
    frame_is_l2
    |-> !checksum_fix)
    else $error("checksum fix on raw ethernet frame");
  a_dr_gate: assert property (@(posedge clock) disable iff (reset)
    delay_response_insert
    |-> rx_insert_enable && tx_cfg_reg[tx_dr_bit])
    else $error("delay response insert without receive insertion");
endmodule
`default_nettype wire

// file: test/mgmt_host.sv
// Management host model: drives the paged register port of the config bank.
// Assumes the bank's clock; read data is valid one cycle after the read edge.
`timescale 1ns/1ps
`default_nettype none
module mgmt_host (
  // Clock
  input wire logic clock,
  // Register port
  output logic [2:0] register_page_select,
  output logic [4:0] reg_addr,
  output logic reg_write,
  output logic reg_read,
  output logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata
);
  initial begin
    register_page_select = 3'h5;
    reg_addr = 5'h00;
    reg_write = 1'b0;
    reg_read = 1'b0;
    reg_wdata = 16'h0000;
  end
  // Strobe, select and fields go out in one write
  task automatic wr(input logic [4:0] a, input logic [15:0] d, input logic [2:0] pg = 3'h5);
    @(posedge clock);
    register_page_select <= pg;
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
    reg_wdata <= ~d;
  endtask
  // Two idle cycles first, so a read never follows a write directly
  task automatic rd(input logic [4:0] a, output logic [15:0] d, input logic [2:0] pg = 3'h5);
    @(posedge clock);
    @(posedge clock);
    register_page_select <= pg;
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1 d = reg_rdata;
  endtask
endmodule
`default_nettype wire

// file: test/tb_ptp_event_tx_timestamp_config.sv
// Testbench: register readback, event capture and transmit decisions.
// Assumes the host model in mgmt_host.sv and the config package.
`timescale 1ns/1ps
`default_nettype none
module tb_ptp_event_tx_timestamp_config;
  import ptp_config_pkg::*;
  logic clock, reset, reg_write, reg_read;
  logic [2:0] register_page_select;
  logic [4:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, frame_udp_port, parser_udp_port, transmit_timestamp_config;
  logic [event_pins-1:0] gpio_in;
  logic [event_units-1:0] event_capture, event_rise_dir;
  logic frame_done, frame_is_l2, frame_is_v6, frame_is_v4, frame_is_sync, frame_is_delay_req;
  logic frame_two_step, frame_crc_bad, frame_ip_assigned, rx_insert_enable;
  logic [3:0] frame_version;
  logic tx_capture, one_step_insert, checksum_fix, force_crc_error, delay_response_insert;
  logic [15:0] d, cfg;
  logic [15:0] word [8];
  logic c, os;
  int fails, total_checks, t;

  ptp_event_tx_timestamp_config DUT (.clock, .reset, .register_page_select, .reg_addr, .reg_write,
    .reg_read, .reg_wdata, .reg_rdata, .gpio_in, .event_capture, .event_rise_dir, .frame_done,
    .frame_udp_port, .frame_is_l2, .frame_is_v6, .frame_is_v4, .frame_is_sync, .frame_is_delay_req,
    .frame_two_step, .frame_crc_bad, .frame_ip_assigned, .frame_version, .rx_insert_enable,
    .tx_capture, .one_step_insert, .checksum_fix, .force_crc_error, .delay_response_insert,
    .parser_udp_port, .transmit_timestamp_config);
  mgmt_host host (.clock, .register_page_select, .reg_addr, .reg_write, .reg_read, .reg_wdata, .reg_rdata);

  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic summarize();
    $display("checks=%0d mismatches=%0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic wait_capture(input int u);
    int n;
    n = 0;
    while (event_capture[u] !== 1'b1) begin
      @(posedge clock);
      #1;
      n++;
      if (n > 30) begin
        fails++;
        $display("timeout waiting for capture on unit %0d", u);
        summarize();
      end
    end
  endtask

  // Capture decision for the frame now on the inputs
  function automatic logic exp_cap(input logic [15:0] k);
    logic udp;
    udp = (frame_is_v6 & k[6]) | (frame_is_v4 & k[5]);
    udp = udp & (frame_udp_port == (k[12] ? 16'h007B : 16'h013F)) & (frame_ip_assigned | ~k[8]);
    return k[0] & ((frame_is_l2 & k[7]) | udp) & (k[4:1] == 4'h0 || k[4:1] == frame_version);
  endfunction

  initial begin
    reset = 1'b1;
    gpio_in = '0;
    frame_done = 1'b0;
    frame_udp_port = 16'h0000;
    {frame_is_l2, frame_is_v6, frame_is_v4, frame_is_sync, frame_is_delay_req} = 5'h00;
    {frame_two_step, frame_crc_bad, frame_ip_assigned, rx_insert_enable} = 4'h0;
    frame_version = 4'h0;
    fails = 0;
    total_checks = 0;
    void'($urandom(32'h3648));
    repeat (6) @(posedge clock);
    reset <= 1'b0;
    host.rd(5'h15, d);
    check(d, 16'h0000);
    host.rd(5'h16, d);
    check(d, 16'h0000);
    check(parser_udp_port, 16'h013F);
    $display("test reset values done");
    // Every unit gets its own word, reserved bits forced high
    for (int u = 0; u < 8; u++) begin
      cfg = 16'($urandom) | 16'h80F1;
      cfg[3:1] = 3'(u);
      host.wr(5'h15, cfg);
      word[u] = cfg & 16'h7F00;
    end
    for (int u = 0; u < 8; u++) begin
      host.wr(5'h15, 16'(u << 1));
      host.rd(5'h15, d);
      check(d, word[u] | 16'(u << 1));
    end
    host.wr(5'h15, 16'h7F0A);
    host.rd(5'h15, d);
    check(d, word[5] | 16'h000A);
    $display("test unit store done");
    // Unit 0 single rising, unit 1 falling, both on pin 3; unit 2 on invalid pin 13
    host.wr(5'h15, 16'h5301);
    host.wr(5'h15, 16'h2303);
    host.wr(5'h15, 16'h4D05);
    @(posedge clock);
    gpio_in[2] <= 1'b1;
    wait_capture(0);
    check(16'(event_rise_dir[0]), 16'h0001);
    check(16'(event_capture[2]), 16'h0000);
    @(posedge clock);
    gpio_in[2] <= 1'b0;
    wait_capture(1);
    check(16'(event_rise_dir[1]), 16'h0000);
    host.wr(5'h15, 16'h0000);
    host.rd(5'h15, d);
    check(d, 16'h1300);
    $display("test event capture done");
    for (int i = 0; i < 4; i++) begin
      cfg = 16'($urandom);
      host.wr(5'h16, cfg);
      host.rd(5'h16, d);
      check(d, cfg & 16'hBFFF);
      check(transmit_timestamp_config, cfg & 16'hBFFF);
    end
    host.wr(5'h16, ~cfg, 3'h4);
    host.rd(5'h16, d);
    check(d, cfg & 16'hBFFF);
    host.rd(5'h16, d, 3'h4);
    check(d, 16'h0000);
    host.rd(5'h14, d);
    check(d, 16'h0000);
    $display("test transmit register done");
    for (int i = 0; i < 90; i++) begin
      if (i % 6 == 0) begin
        cfg = 16'($urandom) & 16'hBFFF;
        if (i % 12 == 0) begin
          cfg[4:1] = 4'h0;
        end
        host.wr(5'h16, cfg);
      end
      @(posedge clock);
      t = $urandom % 3;
      frame_done <= 1'b1;
      frame_is_l2 <= (t == 0);
      frame_is_v6 <= (t == 1);
      frame_is_v4 <= (t == 2);
      frame_udp_port <= ($urandom % 2) ? 16'h013F : 16'h007B;
      frame_version <= ($urandom % 2) ? cfg[4:1] : 4'($urandom);
      {frame_is_sync, frame_is_delay_req, frame_two_step, frame_crc_bad, frame_ip_assigned} <= 5'($urandom);
      rx_insert_enable <= 1'($urandom);
      @(posedge clock);
      frame_done <= 1'b0;
      #1;
      c = exp_cap(cfg);
      os = c & cfg[15] & frame_is_sync & (~frame_two_step | cfg[11]);
      check(16'({tx_capture, one_step_insert}), 16'({c, os}));
      check(16'(force_crc_error), 16'(os & frame_crc_bad & ~cfg[10]));
      check(parser_udp_port, cfg[12] ? 16'h007B : 16'h013F);
      check(16'(checksum_fix), 16'(cfg[9] & ~frame_is_l2));
      check(16'(delay_response_insert), 16'(cfg[13] & rx_insert_enable));
    end
    $display("test transmit frames done");
    summarize();
  end
endmodule
`default_nettype wire
